//--- core/swcd_command_decode.sv
// Command phase decoder of a single-wire serial EEPROM
//
// Contract
// [R1] Each access opens with Start, then an 8-bit device address byte.
// [R2] Top four bits of the device address byte are the command opcode.
// [R3] Bits 3..1 must equal the three fixed slave select bits.
// [R4] Bit 0 selects direction: one reads, zero writes.
// [R5] Valid opcode and matching select bits give an acknowledge, logic zero.
// [R6] Otherwise the line stays undriven until a new Start; back to standby.
// [R7] Memory address byte follows; bits 6..0 are the start, bit 7 ignored.
// [R8] Main array is sixteen pages of eight bytes, 128 locations.
// [R9] Secondary register: four pages; lower two serial, upper two lockable.
// [R10] Opcode 1010 selects main array access.
// [R11] Opcode 1011 selects secondary register access.
// [R12] Opcode 0010 permanently locks the user pages.
// [R13] Opcode 0111 reaches the zone protection register.
// [R14] Opcode 0001 permanently freezes zone protection state.
// [R15] Opcode 1100 returns identification information.
// [R16] Opcode 1101 selects or checks standard speed.
// [R17] Opcode 1110 selects or checks high speed; high speed after reset.
// [R18] Master forms Start by leaving the line released long enough.
// [R19] Acknowledge drives low; not-acknowledge never drives the line.
// [R20] Address bytes shift in most significant bit first.
`timescale 1ns/1ps

module swcd_command_decode
  import swcd_pkg::*;
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  // Decoded bit frames from the frame timer
  input  wire logic                  startCond,
  input  wire logic                  stopCond,
  input  wire logic                  bitStrobe,
  input  wire logic                  bitValue,
  input  wire logic                  ackSlot,
  // Factory slave select straps
  input  wire logic [2:0]            slaveSelect,
  // Data line drive toward the pad
  output logic                       sioOut,
  output logic                       sioOutEn,
  // Decoded command
  output logic                       cmdStart,
  output swcd_opcode_type            cmdOpcode,
  output logic                       cmdRead,
  output logic [MEM_ADDR_W-1:0]      memAddr,
  output logic [PAGE_BIT_W:0]        memPage,
  output logic                       secSerialPage,
  // Mode and status
  output logic                       highSpeed,
  output logic                       secLocked,
  output logic                       zonesFrozen,
  output logic                       standby
);

  swcd_state_type        state;
  swcd_state_type        next_state;
  logic [2:0]            bitCnt;
  logic [BYTE_BITS-1:0]  shiftReg;
  logic [BYTE_BITS-1:0]  byteNow;
  logic                  byteEnd;
  logic                  devAccept;

  function automatic logic isValidOp(input logic [3:0] op);
    case (op)
      OP_FREEZE, OP_LOCK, OP_ZONE, OP_MAIN, OP_SECURITY, OP_IDENT,
      OP_STD_SPD, OP_HIGH_SPD: isValidOp = 1'b1;
      default:                 isValidOp = 1'b0;
    endcase
  endfunction

  function automatic logic isSpeedOp(input logic [3:0] op);
    isSpeedOp = (op == OP_STD_SPD) || (op == OP_HIGH_SPD);
  endfunction

  // Byte so far, newest bit in the LSB, MSB arrived first
  assign byteNow = {shiftReg[BYTE_BITS-2:0], bitValue}; // R20
  assign byteEnd = bitStrobe && (bitCnt == BIT_CNT_LAST);

  // Speed checks answer by ACK only in that speed; lock and freeze checks only while not yet set
  always_comb begin
    devAccept = isValidOp(byteNow[OPC_MSB:OPC_LSB]) // R2 R6
             && (byteNow[SEL_MSB:SEL_LSB] == slaveSelect); // R3
    if (byteNow[RW_BIT]) begin
      unique case (byteNow[OPC_MSB:OPC_LSB])
        OP_STD_SPD:  devAccept = devAccept && !highSpeed; // R16
        OP_HIGH_SPD: devAccept = devAccept && highSpeed; // R17
        OP_LOCK:     devAccept = devAccept && !secLocked;
        OP_FREEZE:   devAccept = devAccept && !zonesFrozen;
        default:     devAccept = devAccept;
      endcase
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: next_state = ST_IDLE;
      ST_DEVADDR: begin
        if (byteEnd) begin
          next_state = devAccept ? ST_ACK_DEV : ST_MUTE; // R5 R6
        end
      end
      ST_ACK_DEV: begin
        if (ackSlot) begin
          next_state = isSpeedOp(cmdOpcode) ? ST_DONE : ST_MEMADDR; // R7
        end
      end
      ST_MEMADDR: begin
        if (byteEnd) begin
          next_state = ST_ACK_MEM;
        end
      end
      ST_ACK_MEM: begin
        if (ackSlot) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: next_state = ST_DONE;
      ST_MUTE: next_state = ST_MUTE;
      default: next_state = ST_IDLE;
    endcase
    // Stop ends anything; Start restarts from any state
    if (stopCond) begin
      next_state = ST_IDLE;
    end
    if (startCond) begin
      next_state = ST_DEVADDR; // R1 R18
    end
  end

  // Sequencing and bit assembly
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state    <= ST_IDLE;
      bitCnt   <= BIT_CNT_RESET;
      shiftReg <= '0;
    end else begin
      state <= next_state;
      if (startCond || (state != next_state)) begin
        bitCnt <= BIT_CNT_RESET;
      end else if (bitStrobe) begin
        bitCnt <= bitCnt + 3'h1;
      end
      if (bitStrobe) begin
        shiftReg <= byteNow; // R20
      end
    end
  end

  // Command capture
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cmdOpcode     <= OP_MAIN;
      cmdRead       <= 1'b0;
      memAddr       <= '0;
      memPage       <= '0;
      secSerialPage <= 1'b0;
    end else begin
      if ((state == ST_DEVADDR) && byteEnd) begin
        cmdOpcode <= swcd_opcode_type'(byteNow[OPC_MSB:OPC_LSB]); // R2
        cmdRead   <= byteNow[RW_BIT]; // R4
      end
      if ((state == ST_MEMADDR) && byteEnd) begin
        memAddr <= byteNow[MEM_ADDR_MSB:0]; // R7
        // Page index: 16 main pages, or 4 secondary pages of 8 bytes
        memPage <= byteNow[MEM_ADDR_MSB:PAGE_BIT_W]; // R8 R9
        // Bits above the secondary page field are don't-care there
        secSerialPage <= (cmdOpcode == OP_SECURITY) // R11
                      && (byteNow[PAGE_BIT_W+1:PAGE_BIT_W]
                          < 2'(SEC_SERIAL_PGS)); // R9
      end
    end
  end

  // Line drive: one-cycle request; the frame timer stretches it to the hold
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sioOut   <= 1'b0;
      sioOutEn <= 1'b0;
      cmdStart <= 1'b0;
      standby  <= 1'b1;
    end else begin
      sioOut   <= 1'b0; // R19
      sioOutEn <= ackSlot
               && ((state == ST_ACK_DEV) || (state == ST_ACK_MEM)); // R5 R19
      cmdStart <= ackSlot && (state == ST_ACK_MEM); // R10 R11 R13 R15
      standby  <= (next_state == ST_IDLE) || (next_state == ST_MUTE); // R6
    end
  end

  // Sticky mode state; lock and freeze only ever set
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      highSpeed   <= HIGH_SPEED_RESET; // R17
      secLocked   <= 1'b0;
      zonesFrozen <= 1'b0;
    end else begin
      if ((state == ST_ACK_DEV) && ackSlot && !cmdRead) begin
        if (cmdOpcode == OP_STD_SPD) begin
          highSpeed <= 1'b0; // R16
        end else if (cmdOpcode == OP_HIGH_SPD) begin
          highSpeed <= 1'b1; // R17
        end
      end
      if ((state == ST_ACK_MEM) && ackSlot && !cmdRead) begin
        if (cmdOpcode == OP_LOCK) begin
          secLocked <= 1'b1; // R12
        end
        if (cmdOpcode == OP_FREEZE) begin
          zonesFrozen <= 1'b1; // R14
        end
      end
    end
  end

  // Checks
  a_start_opens_dev: assert property ( // R1
    @(posedge mclk) disable iff (!rstn)
    startCond |=> (state == ST_DEVADDR) && (bitCnt == BIT_CNT_RESET))
    else $error("start did not open device address phase");

  a_bad_op_mutes: assert property ( // R6
    @(posedge mclk) disable iff (!rstn)
    ((state == ST_DEVADDR) && byteEnd && !startCond && !stopCond
     && !isValidOp(byteNow[OPC_MSB:OPC_LSB])) |=> (state == ST_MUTE))
    else $error("invalid opcode not muted");

  a_sel_mismatch_mutes: assert property ( // R3
    @(posedge mclk) disable iff (!rstn)
    ((state == ST_DEVADDR) && byteEnd && !startCond && !stopCond
     && (byteNow[SEL_MSB:SEL_LSB] != slaveSelect))
    |=> (state == ST_MUTE))
    else $error("select mismatch not muted");

  a_write_acks: assert property ( // R5
    @(posedge mclk) disable iff (!rstn)
    ((state == ST_DEVADDR) && byteEnd && !startCond && !stopCond
     && !byteNow[RW_BIT] && isValidOp(byteNow[OPC_MSB:OPC_LSB])
     && (byteNow[SEL_MSB:SEL_LSB] == slaveSelect))
    |=> (state == ST_ACK_DEV))
    else $error("valid write command not acknowledged");

  a_std_read_gate: assert property ( // R16
    @(posedge mclk) disable iff (!rstn)
    ((state == ST_DEVADDR) && byteEnd && !startCond && !stopCond
     && byteNow[RW_BIT] && highSpeed
     && (byteNow[OPC_MSB:OPC_LSB] == OP_STD_SPD)) |=> (state == ST_MUTE))
    else $error("standard speed check acknowledged in high speed");

  a_ack_answers: assert property ( // R5 R19
    @(posedge mclk) disable iff (!rstn)
    (((state == ST_ACK_DEV) || (state == ST_ACK_MEM)) && ackSlot)
    |=> sioOutEn && !sioOut)
    else $error("acknowledge slot left undriven");

  a_mute_no_drive: assert property ( // R6 R19
    @(posedge mclk) disable iff (!rstn)
    (state == ST_MUTE) [*2] |-> !sioOutEn)
    else $error("line driven while muted");

  a_ack_one_cycle: assert property ( // R5 R19
    @(posedge mclk) disable iff (!rstn)
    sioOutEn |-> !sioOut ##1 !sioOutEn)
    else $error("acknowledge not a single low request");

  a_speed_skips_addr: assert property ( // R16 R17
    @(posedge mclk) disable iff (!rstn)
    ((state == ST_ACK_DEV) && ackSlot && !startCond && !stopCond
     && isSpeedOp(cmdOpcode)) |=> (state == ST_DONE))
    else $error("speed command expected a memory address");

  a_addr_follows_dev: assert property ( // R7
    @(posedge mclk) disable iff (!rstn)
    ((state == ST_ACK_DEV) && ackSlot && !startCond && !stopCond
     && !isSpeedOp(cmdOpcode)) |=> (state == ST_MEMADDR))
    else $error("memory address phase not opened");

  a_rw_captured: assert property ( // R4
    @(posedge mclk) disable iff (!rstn)
    ((state == ST_DEVADDR) && byteEnd)
    |=> (cmdRead == $past(bitValue)))
    else $error("direction bit not captured");

  a_addr_msb_first: assert property ( // R7 R20
    @(posedge mclk) disable iff (!rstn)
    ((state == ST_MEMADDR) && byteEnd)
    |=> (memAddr == $past({shiftReg[5:0], bitValue})))
    else $error("memory address assembled wrongly");

  a_page_index: assert property ( // R8
    @(posedge mclk) disable iff (!rstn)
    ((state == ST_MEMADDR) && byteEnd)
    |=> (memPage == memAddr[MEM_ADDR_W-1:PAGE_BIT_W]))
    else $error("page index does not match address");

  a_serial_page: assert property ( // R9 R11
    @(posedge mclk) disable iff (!rstn)
    ((state == ST_MEMADDR) && byteEnd)
    |=> (secSerialPage
         == ((cmdOpcode == OP_SECURITY) && !memAddr[PAGE_BIT_W+1])))
    else $error("serial page flag wrong");

  a_stop_to_idle: assert property ( // R6
    @(posedge mclk) disable iff (!rstn)
    (stopCond && !startCond) |=> (state == ST_IDLE) && standby)
    else $error("stop did not return to standby");

  a_speed_after_reset: assert property ( // R17
    @(posedge mclk)
    !rstn |=> highSpeed)
    else $error("high speed not selected after reset");

  a_speed_hold: assert property ( // R16 R17
    @(posedge mclk) disable iff (!rstn)
    $changed(highSpeed)
    |-> $past(!rstn || ((state == ST_ACK_DEV) && ackSlot && !cmdRead)))
    else $error("speed changed outside a speed command");

  a_high_speed_set: assert property ( // R17
    @(posedge mclk) disable iff (!rstn)
    ((state == ST_ACK_DEV) && ackSlot && !cmdRead
     && (cmdOpcode == OP_HIGH_SPD)) |=> highSpeed)
    else $error("high speed not applied");

  a_std_speed_set: assert property ( // R16
    @(posedge mclk) disable iff (!rstn)
    ((state == ST_ACK_DEV) && ackSlot && !cmdRead
     && (cmdOpcode == OP_STD_SPD)) |=> !highSpeed ##1 (state != ST_MEMADDR))
    else $error("standard speed not applied");

  a_lock_on_write: assert property ( // R12
    @(posedge mclk) disable iff (!rstn)
    ((state == ST_ACK_MEM) && ackSlot && !cmdRead
     && (cmdOpcode == OP_LOCK)) |=> secLocked)
    else $error("lock command did not lock");

  a_freeze_on_write: assert property ( // R14
    @(posedge mclk) disable iff (!rstn)
    ((state == ST_ACK_MEM) && ackSlot && !cmdRead
     && (cmdOpcode == OP_FREEZE)) |=> zonesFrozen)
    else $error("freeze command did not freeze");

  a_lock_sticky: assert property ( // R12 R14
    @(posedge mclk) disable iff (!rstn)
    (secLocked |=> secLocked) and (zonesFrozen |=> zonesFrozen))
    else $error("permanent lock cleared");

  c_dev_ack: cover property (@(posedge mclk) disable iff (!rstn)
    (state == ST_ACK_DEV) && ackSlot);
  c_main_cmd: cover property (@(posedge mclk) disable iff (!rstn)
    cmdStart && (cmdOpcode == OP_MAIN));
  c_muted: cover property (@(posedge mclk) disable iff (!rstn)
    state == ST_MUTE);
  c_speed_low: cover property (@(posedge mclk) disable iff (!rstn)
    $fell(highSpeed));
  c_lock_set: cover property (@(posedge mclk) disable iff (!rstn)
    $rose(secLocked));

endmodule

//--- core/swcd_pkg.sv
// Constants and types for the single-wire command decoder
package swcd_pkg;

  // Device address byte layout
  localparam int BYTE_BITS   = 8;
  localparam int OPC_MSB     = 7;
  localparam int OPC_LSB     = 4;
  localparam int SEL_MSB     = 3;
  localparam int SEL_LSB     = 1;
  localparam int RW_BIT      = 0;

  // Memory address byte: bit 7 is ignored
  localparam int MEM_ADDR_MSB = 6;
  localparam int MEM_ADDR_W   = 7;

  // Array organisation
  localparam int MAIN_PAGES     = 16;
  localparam int PAGE_BYTES     = 8;
  localparam int MAIN_BYTES     = MAIN_PAGES * PAGE_BYTES;
  localparam int SEC_PAGES      = 4;
  localparam int SEC_SERIAL_PGS = 2;
  localparam int PAGE_BIT_W     = 3;

  // Bit counter limits and values after reset
  localparam logic [2:0] BIT_CNT_RESET    = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST     = 3'h7;
  localparam logic       HIGH_SPEED_RESET = 1'h1;

  typedef enum logic [3:0] {
    OP_FREEZE   = 4'h1,
    OP_LOCK     = 4'h2,
    OP_ZONE     = 4'h7,
    OP_MAIN     = 4'hA,
    OP_SECURITY = 4'hB,
    OP_IDENT    = 4'hC,
    OP_STD_SPD  = 4'hD,
    OP_HIGH_SPD = 4'hE
  } swcd_opcode_type;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_DEVADDR = 3'b001,
    ST_ACK_DEV = 3'b010,
    ST_MEMADDR = 3'b011,
    ST_ACK_MEM = 3'b100,
    ST_DONE    = 3'b101,
    ST_MUTE    = 3'b110
  } swcd_state_type;

endpackage

//--- verification/swcd_master_model.sv
// Bit frame master model feeding the decoder's frame inputs
`timescale 1ns/1ps
module swcd_master_model (
  // Clock
  input  wire logic mclk,
  // Frame pulses toward the device
  output logic      startCond,
  output logic      stopCond,
  output logic      bitStrobe,
  output logic      bitValue,
  output logic      ackSlot,
  // Device drive on the line
  input  wire logic sioOut,
  input  wire logic sioOutEn
);
  initial begin
    {startCond, stopCond, bitStrobe, bitValue, ackSlot} = 5'h00;
  end
  // Start and Stop are a released line held long enough
  task automatic pulse_cond(input logic stp);
    @(negedge mclk);
    if (stp) begin
      stopCond = 1'b1;
    end else begin
      startCond = 1'b1;
    end
    @(negedge mclk);
    {startCond, stopCond} = 2'h0;
  endtask
  task automatic send_byte(input logic [7:0] b, input int nb);
    for (int i = 7; i > 7 - nb; i--) begin
      @(negedge mclk);
      bitStrobe = 1'b1;
      bitValue = b[i];
    end
    @(negedge mclk);
    bitStrobe = 1'b0;
    // Value is meaningless between frames, so it must not linger
    bitValue = ~bitValue;
  endtask
  task automatic ack_frame(output logic ack);
    logic sio;
    @(negedge mclk);
    ackSlot = 1'b1;
    @(negedge mclk);
    ackSlot = 1'b0;
    // Drive request stands one cycle; an undriven line sits at the pull-up
    sio = sioOutEn ? sioOut : 1'b1;
    ack = !sio;
  endtask
endmodule

//--- verification/tb_swcd_command_decode.sv
// Self-checking bench of the single-wire command decoder
`timescale 1ns/1ps
`define CHK(g, e, s) begin n_compared++; if ((g) !== (e)) begin \
  failures++; $display("[ERR] %0t %s", $time, s); end end
module tb_swcd_command_decode
  import swcd_pkg::*;
;
  logic                  mclk, rstn, startCond, stopCond, bitStrobe;
  logic                  bitValue, ackSlot, sioOut, sioOutEn, cmdStart;
  logic                  cmdRead, secSerialPage, highSpeed, secLocked;
  logic                  zonesFrozen, standby, hs, locked, frozen, ack;
  logic [2:0]            slaveSelect;
  logic [MEM_ADDR_W-1:0] memAddr;
  logic [PAGE_BIT_W:0]   memPage;
  logic [31:0]           seed;
  swcd_opcode_type       cmdOpcode;
  int                    failures, n_compared, cycles;

  swcd_command_decode uut (.mclk(mclk), .rstn(rstn),
    .startCond(startCond), .stopCond(stopCond), .bitStrobe(bitStrobe),
    .bitValue(bitValue), .ackSlot(ackSlot), .slaveSelect(slaveSelect),
    .sioOut(sioOut), .sioOutEn(sioOutEn), .cmdStart(cmdStart),
    .cmdOpcode(cmdOpcode), .cmdRead(cmdRead), .memAddr(memAddr),
    .memPage(memPage), .secSerialPage(secSerialPage),
    .highSpeed(highSpeed), .secLocked(secLocked),
    .zonesFrozen(zonesFrozen), .standby(standby));
  swcd_master_model m (.mclk(mclk), .startCond(startCond),
    .stopCond(stopCond), .bitStrobe(bitStrobe), .bitValue(bitValue),
    .ackSlot(ackSlot), .sioOut(sioOut), .sioOutEn(sioOutEn));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic exp_ack(input logic [3:0] op, input logic rd,
                                   input logic [2:0] sel);
    if (sel != slaveSelect) return 1'b0;
    case (op)
      4'hA, 4'hB, 4'h7, 4'hC: return 1'b1;
      4'hD: return !rd || !hs;
      4'hE: return !rd || hs;
      4'h2: return !rd || !locked;
      4'h1: return !rd || !frozen;
      default: return 1'b0;
    endcase
  endfunction
  task automatic print_verdict();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic run_cmd(input logic [3:0] op, input logic rd,
                         input logic [2:0] sel, input logic [7:0] mem);
    logic e;
    e = exp_ack(op, rd, sel);
    m.pulse_cond(1'b0);
    m.send_byte({op, sel, rd}, 8);
    m.ack_frame(ack);
    `CHK(ack, e, "device byte ack")
    `CHK(sioOut, 1'b0, "ack level")
    `CHK(standby, !e, "standby")
    if (e) begin
      `CHK(cmdOpcode, swcd_opcode_type'(op), "opcode")
      `CHK(cmdRead, rd, "direction")
    end
    if (op == 4'hD || op == 4'hE) begin
      if (e && !rd) hs = (op == 4'hE);
    end else begin
      m.send_byte(mem, 8);
      m.ack_frame(ack);
      `CHK(ack, e, "memory byte ack")
      `CHK(cmdStart, e, "command start")
      if (e) begin
        `CHK(memAddr, mem[6:0], "address")
        `CHK(memPage, mem[6:3], "page")
        `CHK(secSerialPage, op == 4'hB && !mem[4], "serial")
        if (!rd && op == 4'h2) locked = 1'b1;
        if (!rd && op == 4'h1) frozen = 1'b1;
      end
    end
    `CHK(highSpeed, hs, "speed")
    `CHK(secLocked, locked, "lock")
    `CHK(zonesFrozen, frozen, "freeze")
    m.pulse_cond(1'b1);
    @(negedge mclk);
    `CHK(standby, 1'b1, "idle after stop")
  endtask

  // Hang guard: normal run needs a few thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    {rstn, failures, n_compared, cycles} = '0;
    seed = xorshift(32'h0000455A);
    slaveSelect = seed[2:0];
    {hs, locked, frozen} = 3'h4;
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    `CHK(highSpeed, 1'b1, "reset speed")
    `CHK(standby, 1'b1, "reset standby")
    `CHK(cmdOpcode, OP_MAIN, "reset opcode")
    m.send_byte({4'hA, slaveSelect, 1'b1}, 8);
    m.ack_frame(ack);
    `CHK(ack, 1'b0, "bits without start")
    // Start inside a byte drops the partial byte
    m.pulse_cond(1'b0);
    m.send_byte(8'hFF, 4);
    run_cmd(4'hA, 1'b1, slaveSelect, 8'hFF);
    // Partial byte at Stop is dropped and the device goes idle
    m.pulse_cond(1'b0);
    m.send_byte(8'hA5, 5);
    m.pulse_cond(1'b1);
    @(negedge mclk);
    `CHK(standby, 1'b1, "partial byte at stop")
    // State checks that answer only before lock or freeze, or only after a change to standard speed
    run_cmd(4'h1, 1'b1, slaveSelect, 8'h5A);
    run_cmd(4'h2, 1'b1, slaveSelect, 8'hA5);
    run_cmd(4'hD, 1'b1, slaveSelect, 8'h00);
    for (int i = 0; i < 32; i++) begin
      seed = xorshift(seed);
      run_cmd(i[4:1], i[0], slaveSelect, seed[7:0]);
    end
    repeat (60) begin
      seed = xorshift(seed);
      run_cmd(seed[3:0], seed[4], seed[7] ? slaveSelect : seed[10:8],
              seed[18:11]);
    end
    print_verdict();
  end
endmodule
